/* File: rtl/wdk_top.sv */
// Keyed watchdog control: AHB-Lite registers, key clear, enable and window mode
//
// Added by the designer: the AHB-Lite register port.
`include "wdk_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module wdk_top #(
    parameter int unsigned TICK_CYCLES = `WDK_TICK_NS / `WDK_CLK_NS
) (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        hsel,
    input  wire logic [15:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    input  wire logic [31:0] cfg_word_1,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             wdt_timeout,
    output logic             wdt_running
);

    // Bus side state
    wdk_pkg::wdk_aphase_t aph_reg;          // Address phase held for the data phase
    wdk_pkg::wdk_aphase_t aph_next;         // Address phase being taken
    logic [31:0]          rdata_reg;        // Read data for the next data phase
    logic [31:0]          rdata_next;       // Read data picked in address phase
    logic                 ready_reg;        // Zero-wait ready flop

    // Control word state
    logic                 on_reg;           // Run-time enable bit
    logic                 on_next;
    logic                 win_reg;          // Window mode enable bit
    logic                 win_next;
    logic [4:0]           ps_reg;           // Postscaler shadow
    logic                 init_reg;         // Configuration load done

    // Watchdog count state
    wdk_pkg::wdk_state_t  state_reg;
    wdk_pkg::wdk_state_t  state_next;
    logic [31:0]          pre_reg;          // Base tick prescaler
    logic [31:0]          pre_next;
    logic [31:0]          count_reg;        // Ticks since last restart
    logic [31:0]          count_next;
    logic                 tout_reg;         // Time-out flag to reset logic
    logic                 run_reg;          // Running flag

    // Decode of the data phase
    wire        dp_wr    = aph_reg.valid & aph_reg.write;
    wire        ctl_hit  = aph_reg.addr[15:2] == `WDK_CTRL_OFS >> 2;
    // Lane 0 carries the window bit, lane 1 the enable bit
    wire        lane0_wr = dp_wr & ctl_hit & (aph_reg.addr[1:0] == 2'h0);
    wire        lane1_wr = dp_wr & ctl_hit & ((aph_reg.addr[1:0] == 2'h1) |
                           ((aph_reg.addr[1:0] == 2'h0) & (aph_reg.size != 3'h0)));
    // Only one half-word write of the key counts; word writes do not
    wire        key_hit  = dp_wr & (aph_reg.addr == `WDK_KEY_OFS) &
                           (aph_reg.size == `WDK_HSIZE_HALF) &
                           (hwdata[`WDK_KEY_MSB:`WDK_KEY_LSB] == `WDK_CLEAR_KEY);

    // Configuration fields; force is sampled live, the postscaler only at the configuration load
    wire        cfg_force = cfg_word_1[`WDK_CFG_FORCE_BIT];
    wire [4:0]  cfg_ps    = cfg_word_1[`WDK_CFG_PS_MSB:`WDK_CFG_PS_LSB];

    // Enable bit only has a say while the config does not force the watchdog on
    wire        run_en    = init_reg & (cfg_force | on_reg);

    // Period in ticks is a power of two chosen by the shadow
    wire [31:0] period    = 32'h1 << ps_reg;
    // Window opens in the last quarter of the period
    wire [31:0] win_start = period - (period >> 2);
    wire        win_open  = count_reg >= win_start;
    // A restart before the window opens is an error in window mode
    wire        early_clr = key_hit & win_reg & ~win_open;
    wire        tick      = pre_reg == TICK_CYCLES - 1;
    wire [31:0] count_inc = count_reg + 32'h1;
    wire        expire    = tick & (count_inc >= period);

    // Address phase capture; idle and busy transfers leave no data phase
    assign aph_next.valid = hsel & htrans[1] & hready;
    assign aph_next.write = hwrite;
    assign aph_next.addr  = haddr;
    assign aph_next.size  = hsize;

    // Control word image as software reads it; key field reads zero
    wire [31:0] ctl_image = {16'h0000, on_reg, 8'h00, ps_reg, win_reg, 1'b0};

    // Read mux; unmapped addresses read zero with an OKAY answer
    assign rdata_next = (~aph_next.valid | aph_next.write) ? rdata_reg :
                        (haddr[15:2] == `WDK_CTRL_OFS >> 2) ? ctl_image :
                        (haddr[15:2] == `WDK_CFG1_OFS >> 2) ? cfg_word_1 :
                        32'h0000_0000;

    // New control bits; the write lands at the end of its data phase
    assign on_next  = lane1_wr ? hwdata[`WDK_ON_BIT] : on_reg;
    assign win_next = lane0_wr ? hwdata[`WDK_WIN_BIT] : win_reg;

    // Prescaler restarts with the count so every period is whole
    assign pre_next = (state_reg != wdk_pkg::WDK_RUN) | key_hit | tick ?
                      32'h0 : pre_reg + 32'h1;

    // Watchdog sequencing
    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        unique case (state_reg)
            // Stopped: count held at zero
            wdk_pkg::WDK_OFF: begin
                count_next = 32'h0;
                if (run_en) begin
                    state_next = wdk_pkg::WDK_RUN;
                end
            end
            // Counting ticks toward the period
            wdk_pkg::WDK_RUN: begin
                if (!run_en) begin
                    state_next = wdk_pkg::WDK_OFF;
                    count_next = 32'h0;
                end else if (early_clr) begin
                    state_next = wdk_pkg::WDK_EXP;
                end else if (key_hit) begin
                    count_next = 32'h0;
                end else if (expire) begin
                    state_next = wdk_pkg::WDK_EXP;
                end else if (tick) begin
                    count_next = count_inc;
                end
            end
            // Expired: held until the reset logic acts
            wdk_pkg::WDK_EXP: begin
                state_next = wdk_pkg::WDK_EXP;
            end
            default: begin
                state_next = wdk_pkg::WDK_EXP;
            end
        endcase
    end

    // Bus flops; the slave never inserts wait states
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            aph_reg   <= '0;
            rdata_reg <= 32'h0000_0000;
            ready_reg <= 1'b0;
        end else begin
            aph_reg   <= aph_next;
            rdata_reg <= rdata_next;
            ready_reg <= 1'b1;
        end
    end

    // Configuration load one edge after reset release; the async
    // reset may only take constants, so the straps are caught here
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            init_reg <= 1'b0;
            on_reg   <= `WDK_ON_RST;
            win_reg  <= `WDK_WIN_RST;
            ps_reg   <= `WDK_PS_RST;
        end else if (!init_reg) begin
            init_reg <= 1'b1;
            on_reg   <= cfg_force;
            win_reg  <= `WDK_WIN_RST;
            ps_reg   <= cfg_ps;
        end else begin
            on_reg   <= on_next;
            win_reg  <= win_next;
        end
    end

    // Count flops and outputs to the reset logic
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= wdk_pkg::WDK_OFF;
            pre_reg   <= 32'h0;
            count_reg <= 32'h0;
            tout_reg  <= 1'b0;
            run_reg   <= 1'b0;
        end else begin
            state_reg <= state_next;
            pre_reg   <= pre_next;
            count_reg <= count_next;
            tout_reg  <= state_next == wdk_pkg::WDK_EXP;
            run_reg   <= state_next == wdk_pkg::WDK_RUN;
        end
    end

    // Outputs come straight from flops; hresp is tied to OKAY
    assign hrdata      = rdata_reg;
    assign hreadyout   = ready_reg;
    assign hresp       = `WDK_RESP_OKAY;
    assign wdt_timeout = tout_reg;
    assign wdt_running = run_reg;

    // Checks on the design's own behaviour
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // Read of the control word in its address phase
    sequence s_ctl_read;
        hsel && htrans[1] && hready && !hwrite && haddr == `WDK_CTRL_OFS;
    endsequence

    // A valid key restarts a running count
    property p_key_clears;
        state_reg == wdk_pkg::WDK_RUN && run_en && key_hit && !early_clr
        |=> count_reg == 32'h0 && state_reg == wdk_pkg::WDK_RUN;
    endproperty
    a_key_clears: assert property (p_key_clears)
        else $error("valid key did not restart count");

    // While running, the count only drops back to zero through a key
    property p_zero_cause;
        state_reg == wdk_pkg::WDK_RUN && $past(state_reg) == wdk_pkg::WDK_RUN &&
        count_reg == 32'h0 && $past(count_reg) != 32'h0 |-> $past(key_hit);
    endproperty
    a_zero_cause: assert property (p_zero_cause)
        else $error("count cleared without a key");

    // Enable low without force stops the count next cycle
    property p_off_stops;
        state_reg == wdk_pkg::WDK_RUN && !on_reg && !cfg_force
        |=> state_reg == wdk_pkg::WDK_OFF && !wdt_running;
    endproperty
    a_off_stops: assert property (p_off_stops)
        else $error("watchdog kept running while disabled");

    // Forced on: never stopped whatever the enable bit says
    property p_force_on;
        (init_reg && cfg_force) [*2] |-> state_reg != wdk_pkg::WDK_OFF;
    endproperty
    a_force_on: assert property (p_force_on)
        else $error("forced watchdog was stopped");

    // Control read returns the shadow in bits 6-2
    property p_shadow_read;
        s_ctl_read ##1 hready |-> hrdata[`WDK_PS_MSB:`WDK_PS_LSB] == ps_reg
                                  && hrdata[`WDK_KEY_MSB:`WDK_KEY_LSB] == 16'h0000;
    endproperty
    a_shadow_read: assert property (p_shadow_read)
        else $error("control read lost the postscaler shadow");

    // Early restart in window mode ends in a time-out
    property p_window_early;
        state_reg == wdk_pkg::WDK_RUN && run_en && early_clr
        |=> state_reg == wdk_pkg::WDK_EXP ##0 wdt_timeout;
    endproperty
    a_window_early: assert property (p_window_early)
        else $error("early restart in window mode not caught");

    // Configuration load after reset release
    property p_cfg_load;
        $rose(init_reg) |-> on_reg == $past(cfg_force) && ps_reg == $past(cfg_ps) && !win_reg;
    endproperty
    a_cfg_load: assert property (p_cfg_load)
        else $error("configuration not loaded at reset");

    // Expiry of the period raises the time-out and it stays
    property p_expire;
        state_reg == wdk_pkg::WDK_RUN && run_en && !key_hit && expire
        |=> wdt_timeout [*3];
    endproperty
    a_expire: assert property (p_expire)
        else $error("period expired without time-out");

    // Time-out is sticky; only reset lets the reset logic see it drop
    property p_timeout_sticky;
        wdt_timeout |=> wdt_timeout;
    endproperty
    a_timeout_sticky: assert property (p_timeout_sticky)
        else $error("time-out dropped without reset");

    // Word write of the control word in its address phase
    sequence s_ctl_write;
        hsel && htrans[1] && hready && hwrite && haddr == `WDK_CTRL_OFS && hsize == 3'h2;
    endsequence

    // A word write lands both control bits at the end of its data phase
    property p_ctl_write;
        s_ctl_write ##1 hready |=> on_reg == $past(hwdata[`WDK_ON_BIT])
                                   && win_reg == $past(hwdata[`WDK_WIN_BIT]);
    endproperty
    a_ctl_write: assert property (p_ctl_write)
        else $error("control word write did not land");

    // A key inside the open window restarts the count with no time-out
    property p_window_late;
        state_reg == wdk_pkg::WDK_RUN && run_en && key_hit && win_reg && win_open
        |=> state_reg == wdk_pkg::WDK_RUN && count_reg == 32'h0 && !wdt_timeout;
    endproperty
    a_window_late: assert property (p_window_late)
        else $error("key inside the window was refused");

    // Read data stands until the next read address phase is taken
    property p_read_stands;
        !(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata);
    endproperty
    a_read_stands: assert property (p_read_stands)
        else $error("read data moved without a read");

endmodule : wdk_top

`default_nettype wire

/* File: rtl/wdk_regs.svh */
// Register offsets, field positions, reset values and timing for the keyed watchdog
`ifndef WDK_REGS_SVH
`define WDK_REGS_SVH
// Byte offset of the watchdog control word
`define WDK_CTRL_OFS        16'h0000
// Byte offset of the upper half-word that takes the key
`define WDK_KEY_OFS         16'h0002
// Byte offset of the read-only configuration word
`define WDK_CFG1_OFS        16'hFFC8
// Key that restarts the count
`define WDK_CLEAR_KEY       16'h5743
// Control word fields
`define WDK_KEY_MSB         31
`define WDK_KEY_LSB         16
`define WDK_ON_BIT          15
`define WDK_PS_MSB          6
`define WDK_PS_LSB          2
`define WDK_WIN_BIT         1
// Configuration word fields
`define WDK_CFG_FORCE_BIT   23
`define WDK_CFG_PS_MSB      20
`define WDK_CFG_PS_LSB      16
// Reset values before the configuration load
`define WDK_ON_RST          1'h0
`define WDK_WIN_RST         1'h0
`define WDK_PS_RST          5'h00
// Clock period and base tick of the count, in ns
`define WDK_CLK_NS          10
`define WDK_TICK_NS         1000
// AHB encodings used by the slave
`define WDK_HSIZE_HALF      3'h1
`define WDK_RESP_OKAY       1'h0
`endif

/* File: rtl/wdk_pkg.sv */
// Types shared by the keyed watchdog control block
`default_nettype none

package wdk_pkg;
    // Captured AHB address phase
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] addr;
        logic [2:0]  size;
    } wdk_aphase_t;

    // Watchdog state, Gray along off -> run -> expired
    typedef enum logic [1:0] {
        WDK_OFF = 2'h0,
        WDK_RUN = 2'h1,
        WDK_EXP = 2'h3
    } wdk_state_t;
endpackage : wdk_pkg

`default_nettype wire

/* File: verif/test_watchdog_control_keyed_clear.sv */
// Self-checking bench for the keyed watchdog control block
`include "wdk_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module test_watchdog_control_keyed_clear;
    localparam int TICK = 2;     // Short tick keeps each period to tens of cycles
    logic        clk;            // 100 MHz clock
    logic        resetn;         // Active-low reset
    logic        hsel;           // Bus select
    logic [15:0] haddr;          // Bus address
    logic [1:0]  htrans;         // Transfer type
    logic        hwrite;         // Write strobe
    logic [2:0]  hsize;          // Transfer size
    logic [31:0] hwdata;         // Write data
    wire  logic  hready;         // Bus ready, the one slave's own answer
    logic [31:0] cfg_word_1;     // Configuration straps
    logic [31:0] hrdata;         // Read data
    logic        hreadyout;      // Slave ready
    logic        wdt_timeout;    // Time-out flag
    logic        wdt_running;    // Count active
    logic        hresp;          // Bus response
    logic        rd_phase;       // Read data phase in progress
    logic        st_chk;         // Status sample strobe
    logic [31:0] rd_q[$];        // Expected read data
    logic [3:0]  st_q[$];        // Expected status and mask
    logic [3:0]  st_exp;         // Status note being compared
    logic [31:0] cfg;            // Straps for the current run
    logic [4:0]  ps;             // Postscaler in the straps
    int          errors;         // Mismatches
    int          check_count;    // Comparisons
    int          seed = 10;      // Fixed seed for repeatable runs

    assign hready = hreadyout;

    wdk_top #(.TICK_CYCLES(TICK)) dut (
        .clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .cfg_word_1(cfg_word_1), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .wdt_timeout(wdt_timeout), .wdt_running(wdt_running)
    );

    // Free-running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Compare one value; case inequality so an unknown never matches
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Monitor: takes the oldest note whenever a result is presented
    always @(posedge clk) begin
        if (rd_phase === 1'b1 && hreadyout === 1'b1 && rd_q.size() > 0) begin
            check("hrdata", hrdata, rd_q.pop_front());
            check("hresp", {31'h0, hresp}, {31'h0, `WDK_RESP_OKAY});
        end
        if (st_chk === 1'b1 && st_q.size() > 0) begin
            st_exp = st_q.pop_front();
            check("status", {30'h0, {wdt_timeout, wdt_running} & st_exp[1:0]},
                  {30'h0, st_exp[3:2] & st_exp[1:0]});
        end
    end

    // Wait until ready is high at a rising edge; registered ready is settled 1 ns after each edge
    task automatic wait_ready;
        #1;
        while (hreadyout !== 1'b1) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
    endtask : wait_ready

    // One single transfer; a read notes its expected data for the monitor
    task automatic ahb(input logic w, input logic [15:0] a, input logic [2:0] s,
                       input logic [31:0] d, input logic [31:0] exp);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= w;
        hsize  <= s;
        wait_ready();
        hsel     <= 1'b0;
        htrans   <= 2'h0;
        hwdata   <= d;
        rd_phase <= ~w;
        if (!w) rd_q.push_back(exp);
        wait_ready();
        rd_phase <= 1'b0;
    endtask : ahb

    // Note expected {timeout, running} with a mask; sampled at the next edge
    task automatic stat(input logic [1:0] e, input logic [1:0] m);
        st_q.push_back({e, m});
        st_chk <= 1'b1;
        @(posedge clk);
        st_chk <= 1'b0;
    endtask : stat

    // Reset with given straps; the config load needs one edge after release
    task automatic do_reset(input logic [31:0] c);
        resetn     <= 1'b0;
        cfg_word_1 <= c;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
    endtask : do_reset

    // Valid key as one half-word write to the upper half
    task automatic kick;
        ahb(1'b1, `WDK_KEY_OFS, `WDK_HSIZE_HALF, {`WDK_CLEAR_KEY, 16'h0000}, 32'h0);
    endtask : kick

    // Verdict and end of run
    task automatic stop_test;
        $display("Checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test

    // Hang guard, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        stop_test();
    end

    // Main sequence
    initial begin
        resetn = 1'b0; hsel = 1'b0; haddr = 16'h0000; htrans = 2'h0; hwrite = 1'b0;
        hsize = 3'h0; hwdata = 32'h0; cfg_word_1 = 32'h0; rd_phase = 1'b0; st_chk = 1'b0;
        errors = 0;
        check_count = 0;
        repeat (2) begin
            // Random straps; postscaler 3 or 4 so each pass of the kick loop fits inside one period
            ps  = 5'(3 + ($random(seed) & 1));
            cfg = $random(seed);
            cfg[23] = 1'b0;
            cfg[20:16] = ps;
            do_reset(cfg);
            ahb(1'b0, `WDK_CTRL_OFS, 3'h2, 32'h0, {16'h0, 1'b0, 8'h00, ps, 2'b00});
            ahb(1'b0, `WDK_CFG1_OFS, 3'h2, 32'h0, cfg);
            ahb(1'b0, 16'h0010, 3'h2, 32'h0, 32'h0);
            stat(2'b00, 2'b11);
            // Word write of all ones: key bits and read-only shadow must not move
            ahb(1'b1, `WDK_CTRL_OFS, 3'h2, 32'hFFFF_FFFF, 32'h0);
            ahb(1'b0, `WDK_CTRL_OFS, 3'h2, 32'h0, {16'h0, 1'b1, 8'h00, ps, 2'b10});
            ahb(1'b1, `WDK_CTRL_OFS, 3'h2, 32'h0000_8000, 32'h0);
            // Valid keys at random spacing keep the count from expiring
            repeat (8) begin
                kick();
                repeat ($random(seed) & 3) @(posedge clk);
            end
            stat(2'b01, 2'b11);
            // Right key in the wrong size or place, wrong key: none restarts
            repeat (8) begin
                ahb(1'b1, `WDK_CTRL_OFS, 3'h2, {`WDK_CLEAR_KEY, 16'h8000}, 32'h0);
                ahb(1'b1, `WDK_KEY_OFS, `WDK_HSIZE_HALF, {`WDK_CLEAR_KEY + 16'h0001, 16'h0000}, 32'h0);
                ahb(1'b1, `WDK_KEY_OFS, 3'h0, {`WDK_CLEAR_KEY, 16'h0000}, 32'h0);
            end
            stat(2'b10, 2'b10);
        end
        // Disabling stops the count, so no time-out however long we wait
        // Enable through the byte lane of bit 15, disable by a half-word write
        do_reset(cfg);
        ahb(1'b1, 16'h0001, 3'h0, 32'h0000_8000, 32'h0);
        repeat (4) @(posedge clk);
        stat(2'b01, 2'b11);
        ahb(1'b1, `WDK_CTRL_OFS, `WDK_HSIZE_HALF, 32'h0000_0000, 32'h0);
        repeat (80) @(posedge clk);
        stat(2'b00, 2'b11);
        // Forced on by the straps: enable reads one, clearing it has no effect
        do_reset(cfg | 32'h0080_0000);
        ahb(1'b0, `WDK_CTRL_OFS, 3'h2, 32'h0, {16'h0, 1'b1, 8'h00, ps, 2'b00});
        ahb(1'b1, `WDK_CTRL_OFS, 3'h2, 32'h0000_0000, 32'h0);
        kick();
        stat(2'b01, 2'b11);
        // Window mode: a key right after start is too early and trips the time-out
        do_reset(cfg);
        ahb(1'b1, `WDK_CTRL_OFS, 3'h2, 32'h0000_8002, 32'h0);
        repeat (3) @(posedge clk);
        kick();
        repeat (3) @(posedge clk);
        stat(2'b10, 2'b10);
        // Window mode: a key once the last quarter has opened restarts as usual
        // Wait of 3/4 period in clocks with a two-clock tick lands inside the window
        do_reset(cfg);
        ahb(1'b1, `WDK_CTRL_OFS, 3'h2, 32'h0000_8002, 32'h0);
        repeat (3 << (ps - 1)) @(posedge clk);
        kick();
        stat(2'b01, 2'b11);
        stop_test();
    end
endmodule : test_watchdog_control_keyed_clear

`default_nettype wire
